// ===== rtl/rqi_top.sv
/*
 * Receiver quality indicators: power capture, carrier sense, preamble and sync
 * quality, quality-gated RX timeout and antenna diversity, which picks an antenna only in static carrier sense mode.
 * Assumes the demodulator delivers power samples, bit strobes and sync correlation
 * on this clock; control bits are plain ports.
 */
`timescale 1ns/1ps
module rqi_top (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        rx_start_i,
	input  wire logic        packet_end_i,
	input  wire logic        abort_strobe_i,
	input  wire logic        low_duty_reload_mode_i,
	input  wire logic [7:0]  rx_power_i,
	input  wire logic        bit_valid_i,
	input  wire logic        bit_i,
	input  wire logic [5:0]  sync_corr_i,
	input  wire logic        sync_corr_valid_i,
	input  wire logic [7:0]  power_threshold_reg_i,
	input  wire logic [1:0]  cs_mode_i,
	input  wire logic        preamble_check_en_i,
	input  wire logic [3:0]  preamble_thresh_sel_i,
	input  wire logic        sync_check_en_i,
	input  wire logic [1:0]  sync_error_allow_i,
	input  wire logic [2:0]  sync_word_length_i,
	input  wire logic [1:0]  timeout_mode_i,
	input  wire logic [29:0] rx_timeout_cycles_i,
	input  wire logic        ant_switch_en_i,
	input  wire logic [2:0]  ant_meas_interval_i,
	input  wire logic [3:0]  channel_filter_exp_i,
	input  wire logic        pin_function_cfg_i,
	output logic      [7:0]  rx_power_level_reg_o,
	output logic             carrier_sense_o,
	output logic             recovery_start_o,
	output logic      [7:0]  preamble_quality_o,
	output logic      [7:0]  sync_quality_o,
	output logic             preamble_valid_irq_o,
	output logic             sync_valid_irq_o,
	output logic             rx_active_o,
	output logic             rx_timeout_o,
	output logic             rx_abort_o,
	output logic      [7:0]  machine_state_reg_o,
	output logic             ant_pin_o
);
	rqi_ant_if ant_bus ();

	logic       cs, next_cs;
	logic [7:0] ref_pwr, next_ref_pwr;
	logic [7:0] level, next_level;
	logic       rx, next_rx;
	logic [29:0] tmr, next_tmr;
	logic       qual_seen, next_qual_seen;
	logic       tmo_pulse, next_tmo_pulse;
	logic       abort_pulse, next_abort_pulse;
	logic [7:0] pq, next_pq;
	logic [7:0] pq_peak, next_pq_peak;
	logic       prev_bit, next_prev_bit;
	logic       have_bit, next_have_bit;
	logic [7:0] sq_peak, next_sq_peak;
	logic       pq_ok, next_pq_ok;
	logic       sq_ok, next_sq_ok;
	logic       pv_irq, next_pv_irq;
	logic       sv_irq, next_sv_irq;
	logic [7:0] dyn_step;
	logic [7:0] cs_low;
	logic [7:0] pq_th;
	logic [7:0] sq_th;
	logic [7:0] sq_in;
	logic       sel_met;
	logic       sync_evt;

	always_comb begin
		case (rqi_pkg::rqi_cs_e'(cs_mode_i))
			rqi_pkg::RQI_CS_DYN6:  dyn_step = rqi_pkg::DYN_STEP_CODE;
			rqi_pkg::RQI_CS_DYN12: dyn_step = 8'(rqi_pkg::DYN_STEP_CODE << 1);
			rqi_pkg::RQI_CS_DYN18: dyn_step = 8'(rqi_pkg::DYN_STEP_CODE * 3);
			default:               dyn_step = 8'h00;
		endcase
		cs_low = (power_threshold_reg_i > rqi_pkg::CS_HYST_CODE) ?
			8'(power_threshold_reg_i - rqi_pkg::CS_HYST_CODE) : 8'h00;
		pq_th = {2'b00, preamble_thresh_sel_i, 2'b00};
		sq_th = 8'({sync_word_length_i, 3'b000} - {5'b0, sync_error_allow_i, 1'b0});
		sq_in = {2'b00, sync_corr_i};
	end

	// Carrier sense state.
	always_comb begin
		next_cs = cs;
		next_ref_pwr = ref_pwr;
		if (!rx) begin
			next_cs = 1'b0;
			next_ref_pwr = rx_power_i;
		end else if (cs_mode_i == 2'b00) begin
			if (rx_power_i > power_threshold_reg_i)
				next_cs = 1'b1;
			else if (rx_power_i < cs_low)
				next_cs = 1'b0;
		end else begin
			if (!cs && rx_power_i > power_threshold_reg_i && rx_power_i >= 8'(ref_pwr + dyn_step)
				&& ref_pwr <= 8'(rqi_pkg::PQ_MAX - dyn_step)) begin
				next_cs = 1'b1;
				next_ref_pwr = rx_power_i;
			end else if (cs && 9'(rx_power_i) + 9'(dyn_step) <= 9'(ref_pwr)) begin
				next_cs = 1'b0;
				next_ref_pwr = rx_power_i;
			end else if (!cs) begin
				next_ref_pwr = rx_power_i;
			end else if (cs && rx_power_i > ref_pwr) begin
				next_ref_pwr = rx_power_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cs <= 1'b0;
			ref_pwr <= rqi_pkg::LEVEL_RESET;
		end else begin
			cs <= next_cs;
			ref_pwr <= next_ref_pwr;
		end
	end

	// Preamble and sync quality.
	always_comb begin
		next_pq = pq;
		next_pq_peak = pq_peak;
		next_prev_bit = prev_bit;
		next_have_bit = have_bit;
		next_sq_peak = sq_peak;
		next_pq_ok = pq_ok;
		next_sq_ok = sq_ok;
		next_pv_irq = 1'b0;
		next_sv_irq = 1'b0;
		if (rx_start_i) begin
			next_pq = 8'h00;
			next_pq_peak = 8'h00;
			next_have_bit = 1'b0;
			next_sq_peak = 8'h00;
			next_pq_ok = 1'b0;
			next_sq_ok = 1'b0;
		end else if (rx) begin
			if (bit_valid_i) begin
				next_prev_bit = bit_i;
				next_have_bit = 1'b1;
				if (have_bit) begin
					if (bit_i != prev_bit)
						next_pq = (pq == rqi_pkg::PQ_MAX) ? pq : 8'(pq + rqi_pkg::PQ_INC);
					else
						next_pq = (pq < rqi_pkg::PQ_DEC) ? 8'h00 : 8'(pq - rqi_pkg::PQ_DEC);
				end
			end
			if (pq > pq_peak)
				next_pq_peak = pq;
			if (sync_corr_valid_i && sq_in > sq_peak)
				next_sq_peak = sq_in;
			if (preamble_check_en_i && !pq_ok && pq_peak > pq_th) begin
				next_pq_ok = 1'b1;
				next_pv_irq = 1'b1;
			end
			if (sync_check_en_i && !sq_ok && sq_peak >= sq_th) begin
				next_sq_ok = 1'b1;
				next_sv_irq = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pq <= 8'h00;
			pq_peak <= 8'h00;
			prev_bit <= 1'b0;
			have_bit <= 1'b0;
			sq_peak <= 8'h00;
			pq_ok <= 1'b0;
			sq_ok <= 1'b0;
			pv_irq <= 1'b0;
			sv_irq <= 1'b0;
		end else begin
			pq <= next_pq;
			pq_peak <= next_pq_peak;
			prev_bit <= next_prev_bit;
			have_bit <= next_have_bit;
			sq_peak <= next_sq_peak;
			pq_ok <= next_pq_ok;
			sq_ok <= next_sq_ok;
			pv_irq <= next_pv_irq;
			sv_irq <= next_sv_irq;
		end
	end

	// Reception window, timeout and level capture.
	always_comb begin
		case (rqi_pkg::rqi_tmo_e'(timeout_mode_i))
			rqi_pkg::RQI_TMO_CS: sel_met = cs;
			rqi_pkg::RQI_TMO_SQ: sel_met = sq_ok;
			rqi_pkg::RQI_TMO_PQ: sel_met = pq_ok;
			default:             sel_met = 1'b1;
		endcase
		sync_evt = sv_irq;
		next_rx = rx;
		next_tmr = tmr;
		next_qual_seen = qual_seen;
		next_tmo_pulse = 1'b0;
		next_abort_pulse = 1'b0;
		next_level = level;
		if (rx_start_i) begin
			next_rx = 1'b1;
			next_tmr = (rx_timeout_cycles_i == '0) ? 30'h1 : rx_timeout_cycles_i;
			next_qual_seen = 1'b0;
		end else if (rx) begin
			if (sel_met)
				next_qual_seen = 1'b1;
			if (abort_strobe_i) begin
				next_rx = 1'b0;
				next_abort_pulse = 1'b1;
				next_level = rx_power_i;
			end else if (packet_end_i) begin
				next_rx = 1'b0;
			end else if (timeout_mode_i != 2'b00 && !qual_seen && !sel_met) begin
				if (tmr == 30'h1) begin
					next_rx = 1'b0;
					next_tmo_pulse = 1'b1;
					next_level = rx_power_i;
				end else begin
					next_tmr = tmr - 30'h1;
				end
			end
			if (sync_evt && !abort_strobe_i)
				next_level = rx_power_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx <= 1'b0;
			tmr <= '0;
			qual_seen <= 1'b0;
			tmo_pulse <= 1'b0;
			abort_pulse <= 1'b0;
			level <= rqi_pkg::LEVEL_RESET;
		end else begin
			rx <= next_rx;
			tmr <= next_tmr;
			qual_seen <= next_qual_seen;
			tmo_pulse <= next_tmo_pulse;
			abort_pulse <= next_abort_pulse;
			level <= next_level;
		end
	end

	assign ant_bus.enable = ant_switch_en_i;
	assign ant_bus.rx_active = rx;
	assign ant_bus.carrier = cs && (cs_mode_i == 2'b00);
	assign ant_bus.power = rx_power_i;
	assign ant_bus.interval = ant_meas_interval_i;
	assign ant_bus.filter_exp = channel_filter_exp_i;

	rqi_ant_sel u_ant (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.port    (ant_bus.sel)
	);

	assign rx_power_level_reg_o = level;
	assign carrier_sense_o = cs;
	assign recovery_start_o = cs;
	assign preamble_quality_o = pq_peak;
	assign sync_quality_o = sq_peak;
	assign preamble_valid_irq_o = pv_irq;
	assign sync_valid_irq_o = sv_irq;
	assign rx_active_o = rx;
	assign rx_timeout_o = tmo_pulse;
	assign rx_abort_o = abort_pulse;
	assign machine_state_reg_o = {5'b0, low_duty_reload_mode_i, ant_bus.frozen, ant_bus.antenna};
	assign ant_pin_o = pin_function_cfg_i & ant_bus.antenna;
endmodule

// ===== shared/rqi_pkg.sv
/*
 * Constants and types shared by the receiver quality block and its antenna selector.
 * Assumes a single 250 MHz clock and a synchronous active-high reset.
 */
package rqi_pkg;
	localparam int PWR_W = 8;
	localparam logic [7:0] PWR_OFFSET_DBM = 8'd130;
	localparam logic [7:0] CS_HYST_CODE = 8'h06;
	localparam logic [7:0] DYN_STEP_CODE = 8'h0c;
	localparam logic [7:0] PQ_MAX = 8'hff;
	localparam logic [7:0] PQ_INC = 8'h01;
	localparam logic [7:0] PQ_DEC = 8'h04;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam int SQ_BITS_PER_BYTE = 8;
	localparam int MEAS_BASE_CYCLES = 24;
	localparam int MEAS_CNT_W = 32;
	localparam int TMO_W = 30;
	localparam real TMO_MIN_US = 1.0;
	localparam real TMO_MAX_S = 3.0;
	localparam int CLK_MHZ = 250;
	localparam int TMO_MIN_CYCLES = (TMO_MIN_US * CLK_MHZ < 1.0) ? 1 : int'(TMO_MIN_US * CLK_MHZ);
	localparam int TMO_MAX_CYCLES = int'(TMO_MAX_S * 1.0e6 * CLK_MHZ);
	typedef enum logic [1:0] {RQI_TMO_INFINITE, RQI_TMO_CS, RQI_TMO_SQ, RQI_TMO_PQ} rqi_tmo_e;
	typedef enum logic [1:0] {RQI_CS_STATIC, RQI_CS_DYN6, RQI_CS_DYN12, RQI_CS_DYN18} rqi_cs_e;
endpackage

// ===== shared/rqi_ant_if.sv
/*
 * Signals between the quality block and its antenna selector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface rqi_ant_if;
	logic       enable;
	logic       rx_active;
	logic       carrier;
	logic [7:0] power;
	logic [2:0] interval;
	logic [3:0] filter_exp;
	logic       antenna;
	logic       frozen;
	modport ctrl (output enable, rx_active, carrier, power, interval, filter_exp, input antenna, frozen);
	modport sel  (input enable, rx_active, carrier, power, interval, filter_exp, output antenna, frozen);
endinterface

// ===== rtl/rqi_ant_sel.sv
/*
 * Antenna diversity selector: toggles antennas while preamble power is measured.
 * Assumes power samples on the same clock and a carrier flag from static sensing.
 */
`timescale 1ns/1ps
module rqi_ant_sel (
	input  wire logic clk_i,
	input  wire logic reset_i,
	rqi_ant_if.sel    port
);
	logic [31:0] cnt, next_cnt;
	logic        ant, next_ant;
	logic        frz, next_frz;
	logic [7:0]  p0, next_p0;
	logic [7:0]  p1, next_p1;
	logic [31:0] span;

	always_comb begin
		span = 32'(rqi_pkg::MEAS_BASE_CYCLES) << (5'(port.filter_exp) + 5'(port.interval));
		next_cnt = cnt;
		next_ant = ant;
		next_frz = frz;
		next_p0 = p0;
		next_p1 = p1;
		if (!port.enable || !port.rx_active) begin
			next_cnt = '0;
			next_frz = 1'b0;
			next_ant = 1'b0;
		end else if (!frz) begin
			if (ant)
				next_p1 = port.power;
			else
				next_p0 = port.power;
			if (port.carrier) begin
				next_frz = 1'b1;
				next_ant = (p1 > p0);
			end else if (cnt + 32'h1 >= span) begin
				next_cnt = '0;
				next_ant = ~ant;
			end else begin
				next_cnt = cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cnt <= '0;
			ant <= 1'b0;
			frz <= 1'b0;
			p0 <= '0;
			p1 <= '0;
		end else begin
			cnt <= next_cnt;
			ant <= next_ant;
			frz <= next_frz;
			p0 <= next_p0;
			p1 <= next_p1;
		end
	end

	assign port.antenna = ant;
	assign port.frozen = frz;
endmodule

// ===== bench/rqi_fe_model.sv
/* Front end model: antenna switch and the power seen behind it.
   Assumes the bench sets the power present on each antenna. */
`timescale 1ns/1ps
module rqi_fe_model (
	input  wire logic       ant_i,
	input  wire logic [7:0] pwr0_i,
	input  wire logic [7:0] pwr1_i,
	output logic      [7:0] rx_power_o
);
	assign rx_power_o = ant_i ? pwr1_i : pwr0_i;
endmodule

// ===== bench/rqi_top_monitor.sv
/* Concurrent checks on the quality block ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module rqi_top_monitor (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       rx_start_i,
	input wire logic       packet_end_i,
	input wire logic       abort_strobe_i,
	input wire logic [7:0] rx_power_i,
	input wire logic [7:0] power_threshold_reg_i,
	input wire logic [1:0] cs_mode_i,
	input wire logic [3:0] preamble_thresh_sel_i,
	input wire logic [1:0] sync_error_allow_i,
	input wire logic [2:0] sync_word_length_i,
	input wire logic [1:0] timeout_mode_i,
	input wire logic       ant_switch_en_i,
	input wire logic       pin_function_cfg_i,
	input wire logic [7:0] rx_power_level_reg_o,
	input wire logic       carrier_sense_o,
	input wire logic [7:0] preamble_quality_o,
	input wire logic [7:0] sync_quality_o,
	input wire logic       preamble_valid_irq_o,
	input wire logic       sync_valid_irq_o,
	input wire logic       rx_active_o,
	input wire logic       rx_timeout_o,
	input wire logic       rx_abort_o,
	input wire logic [7:0] machine_state_reg_o,
	input wire logic       ant_pin_o
);
	logic live;
	assign live = rx_active_o && !rx_start_i && !abort_strobe_i && !packet_end_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	rx_open_a: assert property (rx_start_i |=> rx_active_o)
		else $error("reception not opened");
	abort_capture_a: assert property (abort_strobe_i && rx_active_o && !rx_start_i |=>
		rx_power_level_reg_o == $past(rx_power_i) && !rx_active_o) else $error("abort capture wrong");
	packet_end_a: assert property (rx_active_o && packet_end_i && !rx_start_i && !abort_strobe_i |=>
		!rx_active_o && !rx_abort_o) else $error("packet end did not close reception");
	cs_static_on_a: assert property (live && cs_mode_i == 2'h0 && rx_power_i > power_threshold_reg_i
		|=> carrier_sense_o) else $error("carrier not set");
	cs_hold_a: assert property (live && carrier_sense_o && cs_mode_i == 2'h0 &&
		{1'h0, rx_power_i} + 9'h006 >= {1'h0, power_threshold_reg_i} |=> carrier_sense_o) else $error("hysteresis");
	peak_hold_a: assert property (live |=> preamble_quality_o >= $past(preamble_quality_o) &&
		sync_quality_o >= $past(sync_quality_o)) else $error("peak fell");
	pq_irq_a: assert property (preamble_valid_irq_o |->
		$past(preamble_quality_o) > {2'h0, $past(preamble_thresh_sel_i), 2'h0}) else $error("early preamble flag");
	sq_irq_a: assert property (sync_valid_irq_o |-> {2'h0, sync_quality_o} + {7'h0, sync_error_allow_i, 1'h0}
		>= {4'h0, sync_word_length_i, 3'h0}) else $error("early sync flag");
	tmo_end_a: assert property (rx_timeout_o |-> !rx_active_o && timeout_mode_i != 2'h0 &&
		rx_power_level_reg_o == $past(rx_power_i)) else $error("bad timeout");
	pin_route_a: assert property (ant_pin_o == (pin_function_cfg_i & machine_state_reg_o[0]))
		else $error("pin differs from state");
	sw_off_a: assert property (!ant_switch_en_i [*3] |-> machine_state_reg_o[1:0] == 2'h0)
		else $error("switching while disabled");
endmodule
bind rqi_top rqi_top_monitor mon (.*);

// ===== bench/rqi_top_tb.sv
/* Self-checking bench for the receiver quality block.
   Assumes the monitor is bound in and the front end model supplies power. */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module rqi_top_tb;
	logic clk_i = 0, reset_i = 1, rx_start_i = 0, packet_end_i = 0, abort_strobe_i = 0, bit_valid_i = 0;
	logic low_duty_reload_mode_i = 0, bit_i = 0, sync_corr_valid_i = 0, preamble_check_en_i = 0;
	logic sync_check_en_i = 1, ant_switch_en_i = 0, pin_function_cfg_i = 1;
	logic [7:0] power_threshold_reg_i = 8'h50, pwr0 = 8'h20, pwr1 = 8'h20, rx_power_i;
	logic [5:0] sync_corr_i = 6'h0;
	logic [3:0] preamble_thresh_sel_i = 4'h0, channel_filter_exp_i = 4'h0;
	logic [2:0] sync_word_length_i = 3'h1, ant_meas_interval_i = 3'h0;
	logic [1:0] cs_mode_i = 2'h0, sync_error_allow_i = 2'h0, timeout_mode_i = 2'h0;
	logic [29:0] rx_timeout_cycles_i = 30'h14;
	logic [7:0] rx_power_level_reg_o, preamble_quality_o, sync_quality_o, machine_state_reg_o;
	logic carrier_sense_o, recovery_start_o, preamble_valid_irq_o, sync_valid_irq_o;
	logic rx_active_o, rx_timeout_o, rx_abort_o, ant_pin_o;
	int err_count = 0, num_checks = 0, pq_n = 0, sq_n = 0, to_n = 0, i, g;
	rqi_top uut (.*);
	rqi_fe_model fe (.ant_i(ant_pin_o), .pwr0_i(pwr0), .pwr1_i(pwr1), .rx_power_o(rx_power_i));
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		pq_n += (preamble_valid_irq_o === 1'h1);
		sq_n += (sync_valid_irq_o === 1'h1);
		to_n += (rx_timeout_o === 1'h1);
	end
	task cyc(input int k); repeat (k) @(posedge clk_i); #1; endtask
	task start; @(posedge clk_i) rx_start_i <= 1; @(posedge clk_i) rx_start_i <= 0; endtask
	task stop; @(posedge clk_i) abort_strobe_i <= 1; @(posedge clk_i) abort_strobe_i <= 0; #1; endtask
	task bits(input int k, input logic alt);
		repeat (k) @(posedge clk_i) begin
			bit_valid_i <= 1;
			bit_i <= alt ? ~bit_i : bit_i;
		end
		@(posedge clk_i) bit_valid_i <= 0;
	endtask
	task corr(input logic [5:0] v);
		@(posedge clk_i) begin sync_corr_i <= v; sync_corr_valid_i <= 1; end
		@(posedge clk_i) sync_corr_valid_i <= 0;
		cyc(3);
	endtask
	task gap(output int n);
		logic a;
		a = ant_pin_o;
		n = 0;
		while (ant_pin_o === a && n < 500) begin @(posedge clk_i); #1; n++; end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin cyc(20000); err_count++; print_verdict; end
	initial begin
		cyc(20); reset_i <= 0; cyc(2);
		pwr0 <= 8'h64; start; cyc(3); `CHK(rx_active_o, 1'h1)
		stop; `CHK({rx_abort_o, rx_active_o, rx_power_level_reg_o}, 10'h264)
		$display("abort test done");
		pwr0 <= 8'h20; start; pwr0 <= 8'h51; cyc(3); `CHK(carrier_sense_o, 1'h1)
		`CHK(recovery_start_o, 1'h1)
		pwr0 <= 8'h4a; cyc(3); `CHK(carrier_sense_o, 1'h1)
		pwr0 <= 8'h49; cyc(3); `CHK(carrier_sense_o, 1'h0)
		stop; $display("static sense test done");
		for (i = 1; i < 4; i++) begin
			cs_mode_i <= i[1:0]; pwr0 <= 8'h20; start; cyc(2);
			pwr0 <= 8'h5a - 8'(12 * i); cyc(2); pwr0 <= 8'h58; cyc(3); `CHK(carrier_sense_o, 1'h0)
			pwr0 <= 8'h20; cyc(2); pwr0 <= 8'h70; cyc(3); `CHK(carrier_sense_o, 1'h1)
			pwr0 <= 8'h20; cyc(3); `CHK(carrier_sense_o, 1'h0)
			stop;
		end
		$display("dynamic sense test done");
		cs_mode_i <= 0; preamble_check_en_i <= 1; preamble_thresh_sel_i <= 4'h4; pq_n = 0; start;
		bits(17, 1); cyc(3); `CHK(pq_n, 0)
		bits(1, 1); cyc(3); `CHK(pq_n, 1)
		`CHK(preamble_quality_o, 8'h11)
		bits(10, 0); bits(5, 1); cyc(3); `CHK(preamble_quality_o, 8'h11)
		bits(260, 1); cyc(3); `CHK(preamble_quality_o, 8'hff)
		`CHK(pq_n, 1)
		stop; preamble_check_en_i <= 0; pq_n = 0; start;
		bits(30, 1); cyc(3); `CHK(pq_n, 0)
		stop; $display("preamble test done");
		sync_check_en_i <= 1; sync_word_length_i <= 3'h2;
		for (i = 0; i < 4; i++) begin
			sync_error_allow_i <= i[1:0]; sq_n = 0; start; pwr0 <= 8'h30 + 8'(i);
			corr(6'h0f - 6'(2 * i)); `CHK(sq_n, 0)
			corr(6'h10 - 6'(2 * i)); `CHK(sq_n, 1)
			`CHK(sync_quality_o, 8'h10 - 8'(2 * i))
			`CHK(rx_power_level_reg_o, 8'h30 + 8'(i))
			stop;
		end
		$display("sync test done");
		pwr0 <= 8'h21; preamble_check_en_i <= 1;
		for (i = 0; i < 4; i++) begin
			timeout_mode_i <= i[1:0]; low_duty_reload_mode_i <= (i == 3); to_n = 0; start; cyc(40);
			`CHK(to_n, int'(i != 0))
			`CHK(rx_active_o, i == 0)
		end
		`CHK(machine_state_reg_o[2], 1'h1)
		timeout_mode_i <= 0; start; cyc(3);
		@(posedge clk_i) packet_end_i <= 1; @(posedge clk_i) packet_end_i <= 0; #1;
		`CHK({rx_active_o, rx_abort_o}, 2'h0)
		timeout_mode_i <= 1; pwr0 <= 8'h60; to_n = 0; start; cyc(40); `CHK(to_n, 0)
		stop; $display("timeout test done");
		timeout_mode_i <= 0; pwr0 <= 8'h30; pwr1 <= 8'h40; ant_switch_en_i <= 1;
		ant_meas_interval_i <= 3'h1; channel_filter_exp_i <= 4'h1; start;
		gap(g); gap(g); `CHK(g, 96)
		pwr1 <= 8'h68; gap(g); `CHK(g, 96)
		cyc(6); `CHK(machine_state_reg_o[1:0], 2'h3)
		`CHK(ant_pin_o, 1'h1)
		cyc(100); `CHK(machine_state_reg_o[1:0], 2'h3)
		pin_function_cfg_i <= 0; cyc(2); `CHK(ant_pin_o, 1'h0)
		ant_switch_en_i <= 0; cyc(4); `CHK(machine_state_reg_o[1:0], 2'h0)
		stop; $display("antenna test done");
		print_verdict;
	end
endmodule
